// File: hw/ppm_pkg.sv
// shared constants for the port pin mode multiplexer
package ppm_pkg;
    // pin lane layout: port zero 3:0, port one 7:4, port two 11:8, port five 14:12
    localparam int LANES = 15;
    localparam int IRQS  = 5;
    localparam int INVS  = 6;

    // register byte offsets
    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_DIR    = 8'h04;
    localparam logic [7:0] OFS_PULLUP = 8'h08;
    localparam logic [7:0] OFS_OUT    = 8'h0c;
    localparam logic [7:0] OFS_IN     = 8'h10;
    localparam logic [7:0] OFS_EDGE   = 8'h14;
    localparam logic [7:0] OFS_INVCTL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_MASK   = 8'h20;

    // writable lanes: port two has no driver and no pull-up
    localparam logic [14:0] LANE_MASK = 15'h7fff;
    localparam logic [14:0] DRV_MASK  = 15'h70ff;

    // reset values: port mode, input, pull-up off
    localparam logic [14:0] MODE_RST  = 15'h0000;
    localparam logic [14:0] DIR_RST   = 15'h0000;
    localparam logic [14:0] PU_RST    = 15'h0000;
    localparam logic [14:0] OUT_RST   = 15'h0000;
    localparam logic [9:0]  EDGE_RST  = 10'h000;
    localparam logic [8:0]  INVC_RST  = 9'h000;
    localparam logic [5:0]  STAT_RST  = 6'h00;

    // lane positions of alternate functions
    localparam int L_STOP  = 0;
    localparam int L_CONVERTER_TRIGGER_IN = 3;
    localparam int L_RX    = 4;
    localparam int L_TX    = 5;
    localparam int L_FLASH = 7;
    localparam int L_BYTE  = 12;
    localparam int L_TCAPA = 13;
    localparam int L_TCAPB = 14;
    localparam int P2_LO   = 8;

    // invctl fields: real-time select 5:0, stop enable 8
    localparam int INVC_STOP_EN = 8;
    // status bit of the output-stop event, above the five irq bits
    localparam int ST_STOP = 5;

    // edge select codes, two bits per irq input
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// File: hw/ppm_port_mux.sv
// port pin mode multiplexer with apb register file
// Functional notes
// - per-pin port or control mode bit
// - port zero per-bit direction register
// - port zero per-bit pull-up enable
// - port one direction and pull-up registers
// - port five direction and pull-up registers
// - port two input only, analog alternative
// - irq edge select: rising, falling, both
// - stop input forces inverter outputs off
// - inverter pins select timer or real-time
// - first capture input: clock, both captures
// - second capture input: first register only
// - byte timer clock shares pin with output
// - trigger pin routed to converter
// - system reset pin active low
// - port one pins carry serial rx/tx
// - port one pin selects flash programming
//
// Implementation choices: the register addresses and the APB slave port.
module ppm_port_mux
    import ppm_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // system reset pin, active low, asynchronous to i_clk
    input  wire logic        i_reset_pin_n,
    output logic             o_system_reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             o_irq,
    // port pins
    input  wire logic [3:0]  i_port_zero_pins,
    output logic [3:0]       o_port_zero_pins,
    output logic [3:0]       o_port_zero_pins_oe,
    output logic [3:0]       o_port_zero_pullup_enable,
    input  wire logic [3:0]  i_port_one_pins,
    output logic [3:0]       o_port_one_pins,
    output logic [3:0]       o_port_one_pins_oe,
    output logic [3:0]       o_port_one_pullup_enable,
    input  wire logic [3:0]  i_port_two_input_pins,
    output logic [3:0]       o_analog_inputs_sel,
    input  wire logic [2:0]  i_port_five_pins,
    output logic [2:0]       o_port_five_pins,
    output logic [2:0]       o_port_five_pins_oe,
    output logic [2:0]       o_port_five_pullup_enable,
    // inverter output pins
    output logic [5:0]       o_inverter_pins,
    // from on-chip peripherals, same clock
    input  wire logic [5:0]  i_inverter_timer_outputs,
    input  wire logic [5:0]  i_realtime_port_outputs,
    input  wire logic        i_serial_tx_out,
    input  wire logic        i_gp_timer_out,
    input  wire logic        i_byte_timer_out,
    // to on-chip peripherals
    output logic             o_serial_rx_in,
    output logic             o_flash_prog_select_b,
    output logic             o_converter_trigger_in,
    output logic             o_inverter_output_stop_in,
    output logic             o_gp_timer_clock_capture_in,
    output logic             o_capture_reg_a_trig,
    output logic             o_capture_reg_b_trig,
    output logic             o_byte_timer_clock_in,
    output logic [4:0]       o_ext_irq_req
);

    // edge hit for one irq lane under its select code
    function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise | fall;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

    // pin synchronisers; stage one feeds stage two only
    logic [14:0] meta_q;
    logic [14:0] sync_q;
    logic [14:0] prev_q;
    logic        rst_meta_q;
    logic        rst_sync_q;
    logic [14:0] pins_in;

    // lane order follows the package layout
    assign pins_in = {i_port_five_pins, i_port_two_input_pins, i_port_one_pins, i_port_zero_pins};

    // two-stage sync, third stage keeps last value for edges
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q     <= '0;
            sync_q     <= '0;
            prev_q     <= '0;
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            meta_q     <= pins_in;
            sync_q     <= meta_q;
            prev_q     <= sync_q;
            rst_meta_q <= i_reset_pin_n;
            rst_sync_q <= rst_meta_q;
        end
    end

    logic soft_rst;
    assign soft_rst = ~rst_sync_q;

    // register file
    logic [14:0] mode_q, mode_d;     // 1 = control mode
    logic [14:0] dir_q, dir_d;       // 1 = output
    logic [14:0] pu_q, pu_d;         // pull-up enable
    logic [14:0] out_q, out_d;       // port output latch
    logic [9:0]  edge_q, edge_d;     // irq edge selects
    logic [8:0]  invc_q, invc_d;     // real-time select and stop enable
    logic [5:0]  stat_q, stat_d;     // sticky events
    logic [5:0]  mask_q, mask_d;     // interrupt enables
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;
    logic        ready_q;

    // event detection
    logic [4:0] irq_hit;
    logic [4:0] irq_lane_val;
    logic [4:0] irq_lane_prev;
    logic [4:0] irq_lane_en;
    logic       stop_level;

    // irq lanes: port zero, then the capture pin
    assign irq_lane_val  = {sync_q[L_TCAPA], sync_q[3:0]};
    assign irq_lane_prev = {prev_q[L_TCAPA], prev_q[3:0]};
    assign irq_lane_en   = {mode_q[L_TCAPA], mode_q[3:0]};
    assign stop_level    = mode_q[L_STOP] & ~dir_q[L_STOP] & sync_q[L_STOP];

    // irq edges, one per lane
    genvar g;
    generate
        for (g = 0; g < IRQS; g++) begin : g_irq
            assign irq_hit[g] = irq_lane_en[g] &
                edge_hit(edge_q[2*g+1 -: 2], irq_lane_val[g], irq_lane_prev[g]);
        end
    endgenerate

    // reads latch in setup, writes land in access
    logic setup;
    logic wr_acc;
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;

    // next register state, bus writes and events
    always_comb begin
        logic [5:0] ev;
        ev      = {stop_level & invc_q[INVC_STOP_EN], irq_hit};
        // hold unless a write or event moves it
        mode_d  = mode_q;
        dir_d   = dir_q;
        pu_d    = pu_q;
        out_d   = out_q;
        edge_d  = edge_q;
        invc_d  = invc_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        if (wr_acc) begin
            case (paddr)
                OFS_MODE:   mode_d = pwdata[14:0] & LANE_MASK;
                OFS_DIR:    dir_d  = pwdata[14:0] & DRV_MASK;
                OFS_PULLUP: pu_d   = pwdata[14:0] & DRV_MASK;
                // output latch, port two dropped
                OFS_OUT:    out_d  = pwdata[14:0] & DRV_MASK;
                // two select bits per irq lane
                OFS_EDGE:   edge_d = pwdata[9:0];
                // middle bits stay zero
                OFS_INVCTL: invc_d = {pwdata[INVC_STOP_EN], 2'h0, pwdata[5:0]};
                OFS_MASK:   mask_d = pwdata[5:0];
                // read-only or unmapped: ignored
                default:    ;
            endcase
        end
        // write one to clear; a new event wins over the clear
        if (wr_acc && paddr == OFS_STATUS)
            stat_d = stat_q & ~pwdata[5:0];
        stat_d = stat_d | ev;
        // read data captured in setup, shown in access
        if (setup) begin
            err_d = 1'b0;
            case (paddr)
                OFS_MODE:   rdata_d = {17'h0, mode_q};
                OFS_DIR:    rdata_d = {17'h0, dir_q};
                OFS_PULLUP: rdata_d = {17'h0, pu_q};
                OFS_OUT:    rdata_d = {17'h0, out_q};
                // analog lanes read zero
                OFS_IN:     rdata_d = {17'h0, sync_q & ~(mode_q & ~DRV_MASK)};
                OFS_EDGE:   rdata_d = {22'h0, edge_q};
                OFS_INVCTL: rdata_d = {23'h0, invc_q};
                OFS_STATUS: rdata_d = {26'h0, stat_q};
                OFS_MASK:   rdata_d = {26'h0, mask_q};
                default: begin
                    // unmapped: zero data, error
                    rdata_d = 32'h0;
                    err_d   = 1'b1;
                end
            endcase
        end
    end

    // register file flops
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q  <= MODE_RST;
            dir_q   <= DIR_RST;
            pu_q    <= PU_RST;
            out_q   <= OUT_RST;
            edge_q  <= EDGE_RST;
            invc_q  <= INVC_RST;
            stat_q  <= STAT_RST;
            mask_q  <= STAT_RST;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
            ready_q <= 1'b0;
        end else if (soft_rst) begin
            // pin reset returns defaults
            // held while the synced pin stays low
            mode_q  <= MODE_RST;
            dir_q   <= DIR_RST;
            pu_q    <= PU_RST;
            out_q   <= OUT_RST;
            edge_q  <= EDGE_RST;
            invc_q  <= INVC_RST;
            stat_q  <= STAT_RST;
            mask_q  <= STAT_RST;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            mode_q  <= mode_d;
            dir_q   <= dir_d;
            pu_q    <= pu_d;
            out_q   <= out_d;
            edge_q  <= edge_d;
            invc_q  <= invc_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
            ready_q <= 1'b1;
        end
    end

    // pin and peripheral outputs, all registered
    logic [14:0] pin_q, pin_d;
    logic [14:0] oe_q, oe_d;
    logic [14:0] pue_q, pue_d;
    logic [5:0]  inv_q, inv_d;
    logic [4:0]  ireq_q;
    logic [8:0]  per_q, per_d;
    logic        irq_q, irq_d;
    logic        sysrst_q;

    // pin drive, pull-ups and routed alternate signals
    always_comb begin
        logic [14:0] alt_out;
        logic [14:0] alt_in;
        alt_out        = '0;
        alt_in         = '0;
        alt_out[L_TX]  = i_serial_tx_out;
        // byte timer output on shared pin
        alt_out[L_BYTE]  = i_byte_timer_out;
        alt_out[L_TCAPB] = i_gp_timer_out;
        // control-mode inputs seen only when the pin is not driven
        alt_in = sync_q & mode_q & ~dir_q;
        pin_d  = ((mode_q & alt_out) | (~mode_q & out_q)) & DRV_MASK;
        oe_d   = dir_q & DRV_MASK;
        // tx pin driven whenever in control mode
        oe_d[L_TX] = dir_q[L_TX] | mode_q[L_TX];
        // pull-up only acts on a pin that is an input
        pue_d  = pu_q & ~oe_d & DRV_MASK;
        for (int i = 0; i < INVS; i++) begin
            inv_d[i] = ~(stop_level & invc_q[INVC_STOP_EN]) &
                (invc_q[i] ? i_realtime_port_outputs[i] : i_inverter_timer_outputs[i]);
        end
        per_d[0] = alt_in[L_RX];
        // flash mode select follows the pin in control mode
        per_d[1] = sync_q[L_FLASH] & mode_q[L_FLASH];
        per_d[2] = alt_in[L_CONVERTER_TRIGGER_IN];
        // stop level to the timer
        per_d[3] = stop_level;
        per_d[4] = alt_in[L_TCAPA];
        per_d[5] = alt_in[L_TCAPA] & ~prev_q[L_TCAPA];
        // second input hits first register only
        per_d[6] = per_d[5] | (alt_in[L_TCAPB] & ~prev_q[L_TCAPB]);
        per_d[7] = alt_in[L_BYTE];
        // spare slot, tied low
        per_d[8] = 1'b0;
        // level irq, one edge behind status
        irq_d    = |(stat_q & mask_q);
    end

    // output flops
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_q    <= '0;
            oe_q     <= '0;
            pue_q    <= '0;
            inv_q    <= '0;
            ireq_q   <= '0;
            per_q    <= '0;
            irq_q    <= 1'b0;
            sysrst_q <= 1'b0;
        end else begin
            pin_q    <= pin_d;
            oe_q     <= oe_d;
            pue_q    <= pue_d;
            inv_q    <= inv_d;
            ireq_q   <= irq_hit;
            per_q    <= per_d;
            irq_q    <= irq_d;
            sysrst_q <= rst_sync_q;
        end
    end

    // port wiring, every value from a flop
    assign o_system_reset_n          = sysrst_q;
    assign prdata                    = rdata_q;
    assign pready                    = ready_q;
    assign pslverr                   = err_q;
    assign o_irq                     = irq_q;
    assign o_port_zero_pins          = pin_q[3:0];
    assign o_port_zero_pins_oe       = oe_q[3:0];
    assign o_port_zero_pullup_enable = pue_q[3:0];
    assign o_port_one_pins           = pin_q[7:4];
    assign o_port_one_pins_oe        = oe_q[7:4];
    assign o_port_one_pullup_enable  = pue_q[7:4];
    assign o_analog_inputs_sel       = mode_q[P2_LO+3:P2_LO];
    assign o_port_five_pins          = pin_q[14:12];
    assign o_port_five_pins_oe       = oe_q[14:12];
    assign o_port_five_pullup_enable = pue_q[14:12];
    assign o_inverter_pins           = inv_q;
    assign o_serial_rx_in            = per_q[0];
    assign o_flash_prog_select_b     = per_q[1];
    assign o_converter_trigger_in    = per_q[2];
    assign o_inverter_output_stop_in = per_q[3];
    assign o_gp_timer_clock_capture_in = per_q[4];
    assign o_capture_reg_b_trig      = per_q[5];
    assign o_capture_reg_a_trig      = per_q[6];
    assign o_byte_timer_clock_in     = per_q[7];
    assign o_ext_irq_req             = ireq_q;

endmodule

// File: verification/ppm_port_mux_monitor.sv
// concurrent checks on the port pin multiplexer ports
module ppm_port_mux_monitor (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_reset_pin_n,
    input wire logic       o_system_reset_n,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [3:0] o_port_zero_pins_oe,
    input wire logic [3:0] o_port_zero_pullup_enable,
    input wire logic [3:0] o_port_one_pins_oe,
    input wire logic [3:0] o_port_one_pullup_enable,
    input wire logic [2:0] o_port_five_pins_oe,
    input wire logic [2:0] o_port_five_pullup_enable,
    input wire logic       o_capture_reg_a_trig,
    input wire logic       o_capture_reg_b_trig,
    input wire logic       o_gp_timer_clock_capture_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // reset pin held low or high for three samples
    sequence s_pin_low;
        $fell(i_reset_pin_n) ##1 !i_reset_pin_n [*2];
    endsequence
    sequence s_pin_high;
        $rose(i_reset_pin_n) ##1 i_reset_pin_n [*2];
    endsequence
    property p_zero_wait;
        psel && penable |-> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access phase without ready");
    property p_unmapped;
        psel && !penable && paddr > 8'h20 |=> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_mapped;
        psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access flagged");
    property p_pu_off_driven;
        ((o_port_zero_pins_oe & o_port_zero_pullup_enable) == 4'h0) &&
        ((o_port_one_pins_oe & o_port_one_pullup_enable) == 4'h0) &&
        ((o_port_five_pins_oe & o_port_five_pullup_enable) == 3'h0);
    endproperty
    a_pu_off_driven: assert property (p_pu_off_driven) else $error("pull-up on a driven pin");
    property p_cap_b_with_a;
        o_capture_reg_b_trig |-> o_capture_reg_a_trig;
    endproperty
    a_cap_b_with_a: assert property (p_cap_b_with_a) else $error("second capture alone");
    property p_cap_pulse;
        o_capture_reg_b_trig |=> !o_capture_reg_b_trig;
    endproperty
    a_cap_pulse: assert property (p_cap_pulse) else $error("capture trigger held");
    property p_cap_src;
        o_capture_reg_b_trig |-> ##[0:2] o_gp_timer_clock_capture_in;
    endproperty
    a_cap_src: assert property (p_cap_src) else $error("capture without clock input");
    property p_pin_rst_in;
        s_pin_low |-> ##[0:1] !o_system_reset_n;
    endproperty
    a_pin_rst_in: assert property (p_pin_rst_in) else $error("reset pin not followed");
    property p_pin_rst_out;
        s_pin_high |-> ##[0:1] o_system_reset_n;
    endproperty
    a_pin_rst_out: assert property (p_pin_rst_out) else $error("reset pin release lost");
    property p_pin_defaults;
        !o_system_reset_n [*2] |-> {o_port_zero_pins_oe, o_port_one_pins_oe, o_port_five_pins_oe} == 11'h000;
    endproperty
    a_pin_defaults: assert property (p_pin_defaults) else $error("pin driven in reset");
endmodule

// File: verification/ppm_board_model.sv
// board around the pins: external drivers, pull-ups, floating lines
module ppm_board_model (
    input wire logic        i_clk,
    input wire logic [14:0] i_oe,
    input wire logic [14:0] i_drv,
    input wire logic [14:0] i_pu,
    input wire logic [14:0] i_ext_en,
    input wire logic [14:0] i_ext_val,
    output logic [14:0]     o_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_q = 1'b0; // floating lines wander every cycle
    always @(posedge i_clk) flip_q <= !flip_q;
    assign o_lvl = (i_oe & i_drv) | (~i_oe & i_ext_en & i_ext_val)
                 | (~i_oe & ~i_ext_en & (i_pu | ({15{flip_q}} ^ 15'h5555)));
endmodule

// File: verification/ppm_port_mux_tb_top.sv
// self-checking bench for the port pin multiplexer
module ppm_port_mux_tb_top import ppm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, i_reset_pin_n = 1'b1, o_system_reset_n, pready, pslverr, o_irq;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] i_port_zero_pins, o_port_zero_pins, o_port_zero_pins_oe, o_port_zero_pullup_enable;
    logic [3:0] i_port_one_pins, o_port_one_pins, o_port_one_pins_oe, o_port_one_pullup_enable;
    logic [3:0] i_port_two_input_pins, o_analog_inputs_sel;
    logic [2:0] i_port_five_pins, o_port_five_pins, o_port_five_pins_oe, o_port_five_pullup_enable;
    logic [5:0] o_inverter_pins, i_inverter_timer_outputs = 6'h1a, i_realtime_port_outputs = 6'h25;
    logic i_serial_tx_out = 1'b0, i_gp_timer_out = 1'b0, i_byte_timer_out = 1'b0;
    logic o_serial_rx_in, o_flash_prog_select_b, o_converter_trigger_in, o_inverter_output_stop_in;
    logic o_gp_timer_clock_capture_in, o_capture_reg_a_trig, o_capture_reg_b_trig, o_byte_timer_clock_in;
    logic [4:0] o_ext_irq_req;
    logic [14:0] ext_en = 15'h0, ext_val = 15'h0, lvl;
    int fail_count = 0, checked = 0, cap_a = 0, cap_b = 0, irq_n = 0;
    always #4 i_clk = ~i_clk;
    assign i_port_zero_pins = lvl[3:0];
    assign i_port_one_pins = lvl[7:4];
    assign i_port_two_input_pins = lvl[11:8];
    assign i_port_five_pins = lvl[14:12];
    ppm_board_model u_board (.i_clk(i_clk), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_lvl(lvl),
        .i_oe({o_port_five_pins_oe, 4'h0, o_port_one_pins_oe, o_port_zero_pins_oe}),
        .i_drv({o_port_five_pins, 4'h0, o_port_one_pins, o_port_zero_pins}),
        .i_pu({o_port_five_pullup_enable, 4'h0, o_port_one_pullup_enable, o_port_zero_pullup_enable}));
    ppm_port_mux DUT (.i_clk, .i_rst, .i_reset_pin_n, .o_system_reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .o_irq, .i_port_zero_pins, .o_port_zero_pins, .o_port_zero_pins_oe,
        .o_port_zero_pullup_enable, .i_port_one_pins, .o_port_one_pins, .o_port_one_pins_oe,
        .o_port_one_pullup_enable, .i_port_two_input_pins, .o_analog_inputs_sel, .i_port_five_pins,
        .o_port_five_pins, .o_port_five_pins_oe, .o_port_five_pullup_enable, .o_inverter_pins,
        .i_inverter_timer_outputs, .i_realtime_port_outputs, .i_serial_tx_out, .i_gp_timer_out,
        .i_byte_timer_out, .o_serial_rx_in, .o_flash_prog_select_b, .o_converter_trigger_in,
        .o_inverter_output_stop_in, .o_gp_timer_clock_capture_in, .o_capture_reg_a_trig,
        .o_capture_reg_b_trig, .o_byte_timer_clock_in, .o_ext_irq_req);
    // count capture pulses, one per rising trigger
    always @(posedge i_clk) begin
        if (o_capture_reg_a_trig === 1'b1) cap_a <= cap_a + 1;
        if (o_capture_reg_b_trig === 1'b1) cap_b <= cap_b + 1;
        if (o_ext_irq_req[0] === 1'b1) irq_n <= irq_n + 1;
    end
    // one apb transfer; read data taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 9; k++) if (k != 4) rchk(8'(4 * k), 32'h0);
        chk("oe", 32'h0, {o_port_five_pins_oe, o_port_one_pins_oe, o_port_zero_pins_oe});
        chk("pu", 32'h0, {o_port_five_pullup_enable, o_port_one_pullup_enable, o_port_zero_pullup_enable});
        $display("defaults done");
        apb(1'b1, OFS_DIR, 32'h7fff);
        rchk(OFS_DIR, {17'h0, DRV_MASK});
        apb(1'b1, OFS_OUT, 32'h5a5a);
        rchk(OFS_OUT, 32'h505a);
        chk("p0", 32'hfa, {o_port_zero_pins_oe, o_port_zero_pins});
        chk("p1", 32'hf5, {o_port_one_pins_oe, o_port_one_pins});
        chk("p5", 32'h75, {o_port_five_pins_oe, 1'b0, o_port_five_pins});
        apb(1'b1, OFS_DIR, 32'h0);
        apb(1'b1, OFS_PULLUP, 32'h7fff);
        ext_en <= 15'h0f00;
        ext_val <= 15'h0900;
        rchk(OFS_PULLUP, 32'h70ff);
        chk("pu", 32'h7ff, {o_port_five_pullup_enable, o_port_one_pullup_enable, o_port_zero_pullup_enable});
        rchk(OFS_IN, 32'h79ff);
        apb(1'b1, OFS_MODE, 32'h0f00);
        rchk(OFS_IN, 32'h70ff);
        chk("analog", 32'hf, o_analog_inputs_sel);
        rchk(8'h40, 32'h0);
        chk("slverr", 32'h1, pslverr);
        apb(1'b1, OFS_PULLUP, 32'h0);
        $display("port mode done");
        ext_en <= 15'h0001;
        ext_val <= 15'h0;
        apb(1'b1, OFS_MODE, 32'h1);
        apb(1'b1, OFS_MASK, 32'h1);
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, OFS_EDGE, 32'(c));
            for (int v = 1; v >= 0; v--) begin
                apb(1'b1, OFS_STATUS, 32'h3f);
                ext_val <= 15'(v);
                repeat (6) @(posedge i_clk);
                rchk(OFS_STATUS, 32'(v == 1 ? c & 1 : c >> 1));
                chk("irq", 32'(v == 1 ? c & 1 : c >> 1), o_irq);
            end
        end
        apb(1'b1, OFS_MASK, 32'h0);
        ext_val <= 15'h1;
        repeat (6) @(posedge i_clk);
        chk("masked irq", 32'h0, o_irq);
        apb(1'b1, OFS_MASK, 32'h1);
        repeat (3) @(posedge i_clk);
        chk("unmasked irq", 32'h1, o_irq);
        apb(1'b1, OFS_STATUS, 32'h3f);
        chk("irq req", 32'h5, irq_n);
        $display("interrupts done");
        apb(1'b1, OFS_INVCTL, 32'h3f);
        repeat (2) @(posedge i_clk);
        chk("inv rt", 32'h25, o_inverter_pins);
        apb(1'b1, OFS_INVCTL, 32'h0);
        repeat (2) @(posedge i_clk);
        chk("inv tmr", 32'h1a, o_inverter_pins);
        apb(1'b1, OFS_INVCTL, 32'h100);
        repeat (2) @(posedge i_clk);
        chk("inv stop", 32'h0, o_inverter_pins);
        chk("stop in", 32'h1, o_inverter_output_stop_in);
        rchk(OFS_STATUS, 32'h20);
        $display("inverter done");
        ext_en <= 15'h7099;
        ext_val <= 15'h0;
        apb(1'b1, OFS_MODE, 32'h70b8);
        apb(1'b1, OFS_DIR, 32'h0020);
        ext_val <= 15'h3098;
        repeat (3) @(posedge i_clk);
        ext_val <= 15'h7098;
        i_serial_tx_out <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk("alt in", 32'h1f, {o_converter_trigger_in, o_serial_rx_in, o_flash_prog_select_b,
            o_byte_timer_clock_in, o_gp_timer_clock_capture_in});
        chk("cap a", 32'h2, cap_a);
        chk("cap b", 32'h1, cap_b);
        chk("tx", 32'h3, {o_port_one_pins_oe[1], o_port_one_pins[1]});
        apb(1'b1, OFS_DIR, 32'h5020);
        i_byte_timer_out <= 1'b1;
        i_gp_timer_out <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk("p5 alt", 32'h2d, {o_port_five_pins_oe, o_port_five_pins});
        $display("alternate functions done");
        i_reset_pin_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        chk("sys rst", 32'h0, o_system_reset_n);
        i_reset_pin_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        rchk(OFS_DIR, 32'h0);
        chk("sys run", 32'h1, o_system_reset_n);
        $display("reset pin done");
        give_verdict();
    end
endmodule
bind ppm_port_mux ppm_port_mux_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_reset_pin_n(i_reset_pin_n),
    .o_system_reset_n(o_system_reset_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .o_port_zero_pins_oe(o_port_zero_pins_oe), .o_port_one_pins_oe(o_port_one_pins_oe),
    .o_port_zero_pullup_enable(o_port_zero_pullup_enable), .o_port_five_pins_oe(o_port_five_pins_oe),
    .o_port_one_pullup_enable(o_port_one_pullup_enable), .o_port_five_pullup_enable(o_port_five_pullup_enable),
    .o_capture_reg_a_trig(o_capture_reg_a_trig), .o_capture_reg_b_trig(o_capture_reg_b_trig),
    .o_gp_timer_clock_capture_in(o_gp_timer_clock_capture_in));
